// ---- dac_loader_defines.vh ----
// Constants for the octal DAC serial loader
`ifndef DAC_LOADER_DEFINES_VH
`define DAC_LOADER_DEFINES_VH

// ----------------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------------
`define WORD_BITS       16
`define CODE_MSB        15
`define CODE_LSB        4
`define ADDR_BIT        3
`define SEL_MSB         2
`define SEL_LSB         0
`define CODE_W          12
`define NUM_CH          8
`define LAST_BIT_IDX    5'h0F
`define CNT_RST         5'h00
`define CODE_RST        12'h000
`define WORD_RST        16'h0000

// ----------------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_CH_BASE     8'h10
`define REG_DAC_BASE    8'h30
`define REG_SPAN        8'h20
`define CTRL_STRAP_SEL  0
`define CTRL_SW_STRAP   1
`define CTRL_RST        2'h0

`endif

// ---- edge_sync.v ----
// Two-flop synchroniser with edge detection
`timescale 1ns/1ps
module edge_sync #(
  // Reset value, set to the pin's idle level so no false edge follows reset
  parameter RST_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Asynchronous level in
  input  wire async_i,
  // Synchronised level and edges
  output reg  level_o,
  output wire rise_o,
  output wire fall_o
);
  reg meta_q;
  reg last_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q  <= RST_LEVEL;
      level_o <= RST_LEVEL;
      last_q  <= RST_LEVEL;
    end else begin
      meta_q  <= async_i;
      level_o <= meta_q;
      last_q  <= level_o;
    end
  end

  assign rise_o = level_o & ~last_q;
  assign fall_o = ~level_o & last_q;
endmodule // edge_sync

// ---- dac_loader.v ----
// Serial loader, input latches and DAC latches of an octal 12-bit DAC
`timescale 1ns/1ps
`include "dac_loader_defines.vh"
module dac_loader (
  // Clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // Serial link pins
  input  wire         shift_clock_i,
  input  wire         frame_sync_n_i,
  input  wire         serial_data_in_i,
  output reg          chain_data_out_o,
  // Control pins
  input  wire         device_address_strap_i,
  input  wire         load_all_n_i,
  input  wire         clear_outputs_n_i,
  // APB slave
  input  wire         psel_i,
  input  wire         penable_i,
  input  wire         pwrite_i,
  input  wire [7:0]   paddr_i,
  input  wire [31:0]  pwdata_i,
  output reg  [31:0]  prdata_o,
  output reg          pready_o,
  output reg          pslverr_o,
  // Converter codes, channel A in the low bits, and word accept and reject strobes
  output reg  [95:0]  dac_code_o,
  output reg          word_accepted_o,
  output reg          word_rejected_o
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  wire sclk_lvl, sclk_rise, sclk_fall;
  wire fs_lvl, fs_fall;
  wire sdi_lvl;
  wire strap_lvl;
  wire load_all_n_lvl, clr_lvl;

  // Shift clock idles low
  edge_sync u_sclk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (shift_clock_i),
    .level_o (sclk_lvl),
    .rise_o  (sclk_rise),
    .fall_o  (sclk_fall)
  );

  // Active-low pins idle high
  edge_sync #(.RST_LEVEL(1'b1)) u_fs (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (frame_sync_n_i),
    .level_o (fs_lvl),
    .rise_o  (),
    .fall_o  (fs_fall)
  );

  edge_sync u_sdi (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (serial_data_in_i),
    .level_o (sdi_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  edge_sync u_strap (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (device_address_strap_i),
    .level_o (strap_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  edge_sync #(.RST_LEVEL(1'b1)) u_load_all_n (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (load_all_n_i),
    .level_o (load_all_n_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  edge_sync #(.RST_LEVEL(1'b1)) u_clr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (clear_outputs_n_i),
    .level_o (clr_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  // --------------------------------------------------------------------
  // Serial shift engine
  // --------------------------------------------------------------------
  reg  [15:0]  shift_q;
  reg  [4:0]   bit_cnt_q;
  reg          armed_q;
  reg          pend_out_q;
  reg  [1:0]   ctrl_q;
  reg  [95:0]  in_lat_q;
  reg  [15:0]  last_word_q;
  reg  [7:0]   acc_cnt_q;
  reg  [7:0]   rej_cnt_q;

  wire [15:0] word_d   = {shift_q[14:0], sdi_lvl};
  wire        strap_eff = ctrl_q[`CTRL_STRAP_SEL] ? ctrl_q[`CTRL_SW_STRAP] : strap_lvl;
  wire        take_bit  = sclk_fall & ~fs_lvl & armed_q;
  wire        last_bit  = (bit_cnt_q == `LAST_BIT_IDX);
  wire        addr_ok   = (word_d[`ADDR_BIT] == strap_eff);

  // 12-bit slot of a channel within a packed latch bank
  function [11:0] slot;
    input [95:0] bank;
    input [2:0]  idx;
    begin
      slot = bank[idx*12 +: 12];
    end
  endfunction

  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      shift_q          <= `WORD_RST;
      bit_cnt_q        <= `CNT_RST;
      armed_q          <= 1'b0;
      pend_out_q       <= 1'b0;
      chain_data_out_o <= 1'b0;
      in_lat_q         <= 96'h0;
      last_word_q      <= `WORD_RST;
      acc_cnt_q        <= 8'h00;
      rej_cnt_q        <= 8'h00;
      word_accepted_o  <= 1'b0;
      word_rejected_o  <= 1'b0;
    end else begin
      word_accepted_o <= 1'b0;
      word_rejected_o <= 1'b0;
      if (fs_lvl) begin
        bit_cnt_q <= `CNT_RST;
        armed_q   <= 1'b0;
      end else if (fs_fall) begin
        armed_q   <= 1'b1;
        bit_cnt_q <= `CNT_RST;
      end
      if (take_bit) begin
        shift_q    <= word_d;
        pend_out_q <= sdi_lvl;
        bit_cnt_q  <= bit_cnt_q + 5'h01;
        if (last_bit) begin
          armed_q     <= 1'b0;
          last_word_q <= word_d;
          if (addr_ok) begin
            for (i = 0; i < `NUM_CH; i = i + 1) begin
              if (word_d[`SEL_MSB:`SEL_LSB] == i[2:0]) begin
                in_lat_q[i*12 +: 12] <= word_d[`CODE_MSB:`CODE_LSB];
              end
            end
            word_accepted_o <= 1'b1;
            acc_cnt_q       <= acc_cnt_q + 8'h01;
          end else begin
            word_rejected_o <= 1'b1;
            rej_cnt_q       <= rej_cnt_q + 8'h01;
          end
        end
      end
      if (sclk_rise) begin
        chain_data_out_o <= pend_out_q;
      end
    end
  end

  // --------------------------------------------------------------------
  // DAC latches
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      dac_code_o <= 96'h0;
    end else if (!clr_lvl) begin
      dac_code_o <= 96'h0;
    end else if (!load_all_n_lvl) begin
      dac_code_o <= in_lat_q[95:0];
    end
  end

  // --------------------------------------------------------------------
  // APB slave, one wait state before pready
  // --------------------------------------------------------------------
  wire apb_acc = psel_i & penable_i & ~pready_o;
  wire [7:0] off = paddr_i - `REG_CH_BASE;
  wire [7:0] doff = paddr_i - `REG_DAC_BASE;
  wire in_ch  = (paddr_i >= `REG_CH_BASE) && (paddr_i < `REG_CH_BASE + `REG_SPAN);
  wire in_dac = (paddr_i >= `REG_DAC_BASE) && (paddr_i < `REG_DAC_BASE + `REG_SPAN);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q    <= `CTRL_RST;
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= apb_acc;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
      if (apb_acc) begin
        if (paddr_i[1:0] != 2'b00) begin
          pslverr_o <= 1'b1;
        end else if (paddr_i == `REG_CTRL) begin
          if (!pwrite_i) prdata_o <= {30'h0, ctrl_q};
        end else if (paddr_i == `REG_STATUS) begin
          if (pwrite_i) pslverr_o <= 1'b1;
          else prdata_o <= {last_word_q, rej_cnt_q[3:0], acc_cnt_q[3:0],
                            3'h0, strap_lvl, armed_q, ~fs_lvl, clr_lvl, load_all_n_lvl};
        end else if (in_ch && !pwrite_i) begin
          prdata_o <= {20'h0, slot(in_lat_q[95:0], off[4:2])};
        end else if (in_dac && !pwrite_i) begin
          prdata_o <= {20'h0, slot(dac_code_o, doff[4:2])};
        end else begin
          pslverr_o <= 1'b1;
        end
      end
      // Control write lands at the edge where the master sees pready
      if (psel_i && penable_i && pready_o && pwrite_i && (paddr_i == `REG_CTRL)) begin
        ctrl_q <= pwdata_i[1:0];
      end
    end
  end
endmodule // dac_loader

// ---- loader_checker_assertions.sv ----
// Port assertions for the octal DAC serial loader
`timescale 1ns/1ps
module loader_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        shift_clock_i,
  input wire        frame_sync_n_i,
  input wire        load_all_n_i,
  input wire        clear_outputs_n_i,
  input wire        chain_data_out_o,
  input wire [95:0] dac_code_o,
  input wire        word_accepted_o,
  input wire        word_rejected_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire done = word_accepted_o | word_rejected_o;
  wire idle = load_all_n_i & clear_outputs_n_i;
  chk_flag_excl: assert property (!(word_accepted_o && word_rejected_o))
    else $error("accept and reject together");
  chk_result_gap: assert property (done |=> !done [*8])
    else $error("word results too close");
  chk_idle_quiet: assert property (frame_sync_n_i [*8] |-> !done)
    else $error("word result outside a frame");
  chk_chain_idle: assert property (!shift_clock_i [*6] |-> $stable(chain_data_out_o))
    else $error("chain output moved without a rise");
  chk_chain_rise: assert property ($changed(chain_data_out_o) |->
    $past(shift_clock_i, 2) || $past(shift_clock_i, 3) || $past(shift_clock_i, 4))
    else $error("chain output change not after a rise");
  chk_clear_zero: assert property (!clear_outputs_n_i [*5] |-> dac_code_o == 96'h0)
    else $error("clear did not zero outputs");
  chk_clear_keep: assert property (
    !clear_outputs_n_i [*5] ##1 idle [*5] |-> dac_code_o == 96'h0)
    else $error("outputs left zero without a load");
  chk_dac_hold: assert property (idle [*5] |=> $stable(dac_code_o))
    else $error("outputs moved without load");
  cover property (word_accepted_o);
  cover property (word_rejected_o);
  cover property (!clear_outputs_n_i [*5]);
endmodule // loader_checker
bind dac_loader loader_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .shift_clock_i(shift_clock_i), .frame_sync_n_i(frame_sync_n_i),
  .load_all_n_i(load_all_n_i), .clear_outputs_n_i(clear_outputs_n_i),
  .chain_data_out_o(chain_data_out_o), .dac_code_o(dac_code_o),
  .word_accepted_o(word_accepted_o), .word_rejected_o(word_rejected_o));

// ---- host_link_model.sv ----
// Serial host model driving the loader link pins
`timescale 1ns/1ps
module host_link_model #(
  parameter int HALF = 4
) (
  input  wire         clk_i,
  input  wire         chain_i,
  output logic        shift_clock_o = 1'b0,
  output logic        frame_sync_n_o = 1'b1,
  output logic        serial_data_o = 1'b0,
  output logic [15:0] echo_o = 16'h0000
);
  // Fewer than sixteen bits gives a deliberately cut frame
  task automatic send(input logic [15:0] w, input int nbits);
    integer i;
    @(posedge clk_i) shift_clock_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    frame_sync_n_o <= 1'b0;
    serial_data_o <= w[15];
    for (i = 15; i >= 16 - nbits; i--) begin
      repeat (HALF) @(posedge clk_i);
      shift_clock_o <= 1'b0;
      repeat (HALF - 1) @(posedge clk_i);
      @(negedge clk_i);
      if (i < 15) echo_o = {echo_o[14:0], chain_i};
      @(posedge clk_i);
      shift_clock_o <= 1'b1;
      if (i > 0) serial_data_o <= w[i - 1];
    end
    repeat (2 * HALF - 1) @(posedge clk_i);
    @(negedge clk_i);
    echo_o = {echo_o[14:0], chain_i};
    @(posedge clk_i);
    frame_sync_n_o <= 1'b1;
    // Released data line shows no stale bit
    serial_data_o <= ~serial_data_o;
    repeat (HALF) @(posedge clk_i);
    shift_clock_o <= 1'b0;
  endtask
endmodule // host_link_model

// ---- test_octal_dac_serial_loader.sv ----
// Self-checking bench for the octal DAC serial loader
`timescale 1ns/1ps
module test_octal_dac_serial_loader;
  logic        clk_i, rst_i, psel, penable, pwrite, strap, load_n, clear_n, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr;
  wire         sck, fs_n, sd, chain, acc, rej;
  wire  [95:0] dac;
  wire  [15:0] echo;
  logic [15:0] rnd, w;
  logic [11:0] in_m [8] = '{default: 12'h000};
  logic [95:0] dac_m = 96'h0;
  int          error_cnt = 0, checks_done = 0, cyc = 0, acc_n = 0, rej_n = 0, ea = 0, er = 0;
  dac_loader dut_u (.clk_i(clk_i), .rst_i(rst_i), .shift_clock_i(sck), .frame_sync_n_i(fs_n),
    .serial_data_in_i(sd), .chain_data_out_o(chain), .device_address_strap_i(strap),
    .load_all_n_i(load_n), .clear_outputs_n_i(clear_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .dac_code_o(dac),
    .word_accepted_o(acc), .word_rejected_o(rej));
  host_link_model #(.HALF(4)) host_u (.clk_i(clk_i), .chain_i(chain), .shift_clock_o(sck),
    .frame_sync_n_o(fs_n), .serial_data_o(sd), .echo_o(echo));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (acc === 1'b1) acc_n <= acc_n + 1;
    if (rej === 1'b1) rej_n <= rej_n + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pins(input logic l, input logic c);
    @(posedge clk_i);
    load_n <= l;
    clear_n <= c;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {rst_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {strap, load_n, clear_n, rnd} = {3'b111, 16'h0042};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      rnd = lfsr(rnd);
      w = {rnd[11:0], rnd[12] ^ (k == 8), k[2:0]};
      strap <= rnd[12];
      if (k == 3) host_u.send(~w, 5);
      host_u.send(w, 16);
      repeat (8) @(posedge clk_i);
      if (k != 8) in_m[k % 8] = w[15:4];
      if (k != 8) ea++;
      else er++;
      chk(echo, w);
      chk({acc_n, rej_n}, {ea, er});
      apb(1'b0, 8'(16 + 4 * (k % 8)), 32'h0, rd, err);
      chk(rd[11:0], in_m[k % 8]);
      chk(dac, dac_m);
    end
    $display("serial word test done");
    for (int n = 0; n < 8; n++) dac_m[n * 12 +: 12] = in_m[n];
    pins(1'b0, 1'b1);
    pins(1'b1, 1'b1);
    chk(dac, dac_m);
    pins(1'b0, 1'b0);
    chk(dac, 96'h0);
    pins(1'b1, 1'b1);
    chk(dac, 96'h0);
    pins(1'b0, 1'b1);
    chk(dac, dac_m);
    pins(1'b1, 1'b1);
    $display("load and clear test done");
    apb(1'b1, 8'h00, {30'h0, ~strap, 1'b1}, rd, err);
    apb(1'b0, 8'h00, 32'h0, rd, err);
    chk(rd, {30'h0, ~strap, 1'b1});
    rnd = lfsr(rnd);
    w = {rnd[11:0], ~strap, 3'h5};
    host_u.send(w, 16);
    repeat (8) @(posedge clk_i);
    in_m[5] = w[15:4];
    ea++;
    chk({acc_n, rej_n}, {ea, er});
    apb(1'b0, 8'h24, 32'h0, rd, err);
    chk(rd[11:0], in_m[5]);
    apb(1'b1, 8'h00, 32'h0, rd, err);
    $display("software strap test done");
    apb(1'b0, 8'h80, 32'h0, rd, err);
    chk(err, 1'b1);
    apb(1'b1, 8'h10, {20'h00000, rnd[11:0]}, rd, err);
    chk(err, 1'b1);
    $display("register error test done");
    report_and_stop();
  end
endmodule // test_octal_dac_serial_loader
